// file: core/cam_defines.vh
// Functional notes
// R1 - The memory holds 32 stored words of 32 bits, and every word is compared with the search key.
// R2 - A stored bit written as don't-care is left out of the comparison, so it never blocks or causes a match.
// R3 - In encoded mode the result is the binary address of the matching word.
// R4 - In unencoded mode a 16-line vector shows words 0-15 and then words 16-31 on two cycles, and the reader samples both.
// R5 - Encoded users must not store the same data twice; the unencoded vector reports every match.
// R6 - Contents can be preloaded at configuration and can also be written word by word in operation.
// R7 - A word write takes two cycles, or three with don't-care bits, and the writer holds the write for the full count.
// R8 - Input and output sides run on separate enables, with optional input and output registers.
// R9 - Input and output sides are gated by clock enables, and the pipeline answers an asynchronous clear.
// R10 - A match-found flag goes with every result, so an encoded address of zero is unambiguous.
`ifndef CAM_DEFINES_VH
`define CAM_DEFINES_VH

// ==================================================
// Geometry
`define CAM_WORDS        32
`define CAM_WIDTH        32
`define CAM_AW           5
`define CAM_HALF         16

// ==================================================
// Write timing in cycles
`define CAM_WR_CYC_PLAIN 2'd2
`define CAM_WR_CYC_MASK  2'd3

// ==================================================
// Register map, byte offsets
`define CAM_OFS_CTRL     4'h0
`define CAM_OFS_STATUS   4'h4
`define CAM_OFS_VECTOR   4'h8

// ==================================================
// Field positions and the control reset value
`define CAM_CTRL_UNENC   0
`define CAM_ST_FOUND     0
`define CAM_ST_ADDR_LSB  8
`define CAM_ST_BUSY      16
`define CAM_CTRL_RST     1'b0

`endif

// file: core/cam_core.v
`timescale 1ns/10ps
`include "cam_defines.vh"

module cam_core #(
	parameter                         P_IN_REG    = 1,
	parameter                         P_OUT_REG   = 0,
	parameter [`CAM_WORDS*`CAM_WIDTH-1:0] P_INIT_DATA = {(`CAM_WORDS*`CAM_WIDTH){1'b0}},
	parameter [`CAM_WORDS*`CAM_WIDTH-1:0] P_INIT_CARE = {(`CAM_WORDS*`CAM_WIDTH){1'b0}},
	parameter [`CAM_WORDS-1:0]        P_INIT_VALID = {`CAM_WORDS{1'b0}}
) (
	input  wire                   i_clk,
	input  wire                   i_rstn,
	input  wire                   i_aclr,
	input  wire                   i_in_ce,
	input  wire                   i_out_ce,
	input  wire                   i_read_strobe,
	input  wire [`CAM_WIDTH-1:0]  i_key,
	input  wire                   i_wr_en,
	input  wire [`CAM_AW-1:0]     i_wr_addr,
	input  wire [`CAM_WIDTH-1:0]  i_wr_data,
	input  wire [`CAM_WIDTH-1:0]  i_wr_care,
	output wire                   o_wr_done,
	output wire                   o_res_valid,
	output wire                   o_res_found,
	output wire [`CAM_AW-1:0]     o_res_addr,
	output wire [`CAM_HALF-1:0]   o_res_vec,
	output wire                   o_res_upper,
	input  wire [3:0]             i_avs_address,
	input  wire                   i_avs_read,
	input  wire                   i_avs_write,
	input  wire [31:0]            i_avs_writedata,
	input  wire [3:0]             i_avs_byteenable,
	output wire [31:0]            o_avs_readdata,
	output wire                   o_avs_waitrequest
);

	// ==================================================
	// Storage
	reg  [`CAM_WIDTH-1:0]  mem_data_r [0:`CAM_WORDS-1];
	reg  [`CAM_WIDTH-1:0]  mem_care_r [0:`CAM_WORDS-1];
	reg  [`CAM_WORDS-1:0]  mem_valid_r;
	reg  [1:0]             wcnt_r;
	reg                    wr_done_r;
	wire [1:0]             wr_need;
	wire                   wr_commit;

	// A set care bit marks that stored bit as don't-care; care bits sit
	// beside the data so a masked position drops out of every compare.
	// The mask also picks the write count, so it must stay put all along.
	assign wr_need   = (|i_wr_care) ? `CAM_WR_CYC_MASK : `CAM_WR_CYC_PLAIN; // R7
	assign wr_commit = i_in_ce & i_wr_en & (wcnt_r + 2'd1 == wr_need); // R7

	// Write cycle counter, restarts whenever the strobe drops early in an input-enabled cycle
	// A cut write is lost: nothing reaches the array before the full count
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wcnt_r    <= 2'd0;
			wr_done_r <= 1'b0;
		end else begin
			wr_done_r <= wr_commit;
			if (i_in_ce) begin
				if (!i_wr_en || wr_commit) begin
					wcnt_r <= 2'd0;
				end else begin
					wcnt_r <= wcnt_r + 2'd1; // R7
				end
			end
		end
	end

	// Word array: preload on reset, user writes afterwards
	// Preload values come from parameters, so the reset branch stays constant
	genvar gi;
	generate
		for (gi = 0; gi < `CAM_WORDS; gi = gi + 1) begin : g_word
			always @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					mem_data_r[gi]  <= P_INIT_DATA[gi*`CAM_WIDTH +: `CAM_WIDTH]; // R6
					mem_care_r[gi]  <= P_INIT_CARE[gi*`CAM_WIDTH +: `CAM_WIDTH];
					mem_valid_r[gi] <= P_INIT_VALID[gi];
				end else if (wr_commit && i_wr_addr == gi) begin
					mem_data_r[gi]  <= i_wr_data; // R6
					mem_care_r[gi]  <= i_wr_care; // R2
					mem_valid_r[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// ==================================================
	// Input side
	reg  [`CAM_WIDTH-1:0]  key_r;
	reg                    srch_r;
	wire [`CAM_WIDTH-1:0]  key_s;
	wire                   srch_s;

	// Optional input register on key and read strobe
	// The clear empties the strobe so no search survives it
	always @(posedge i_clk or negedge i_rstn or posedge i_aclr) begin
		if (!i_rstn || i_aclr) begin
			key_r  <= {`CAM_WIDTH{1'b0}}; // R9
			srch_r <= 1'b0;
		end else if (i_in_ce) begin
			key_r  <= i_key; // R8
			srch_r <= i_read_strobe;
		end else begin
			srch_r <= 1'b0;
		end
	end

	// Without the input register the strobe is qualified by the enable
	// here, so a search outside an enabled cycle is never seen
	assign key_s  = (P_IN_REG != 0) ? key_r : i_key; // R8
	assign srch_s = (P_IN_REG != 0) ? srch_r : (i_read_strobe & i_in_ce);

	// ==================================================
	// Compare array
	// Words never written and not preloaded stay invalid and never match
	wire [`CAM_WORDS-1:0]  hit;

	generate
		for (gi = 0; gi < `CAM_WORDS; gi = gi + 1) begin : g_cmp
			assign hit[gi] = mem_valid_r[gi] &
				~|((mem_data_r[gi] ^ key_s) & ~mem_care_r[gi]); // R1 R2
		end
	endgenerate

	// Lowest matching index wins the encoded result. With duplicate words
	// the address names only one of them; the vector shows them all.
	function [`CAM_AW-1:0] cam_enc;
		input [`CAM_WORDS-1:0] v;
		integer k;
		begin
			cam_enc = {`CAM_AW{1'b0}};
			for (k = `CAM_WORDS - 1; k >= 0; k = k - 1) begin
				if (v[k]) begin
					cam_enc = k[`CAM_AW-1:0];
				end
			end
		end
	endfunction

	// ==================================================
	// Output side
	reg                    ctrl_unenc_r;
	reg                    phase_r;
	reg  [`CAM_WORDS-1:0]  vec_hold_r;
	reg                    val_r;
	reg                    found_r;
	reg  [`CAM_AW-1:0]     addr_r;
	reg  [`CAM_HALF-1:0]   vec_r;
	reg                    upper_r;
	wire                   take;

	// A new search is refused while the upper half is pending; holding it
	// off keeps the two beats of an unencoded result back to back
	assign take = srch_s & i_out_ce & ~phase_r;

	// Result stage: encoded address, flag, and two-cycle vector
	// The upper half comes from the copy held at the lower beat
	always @(posedge i_clk or negedge i_rstn or posedge i_aclr) begin
		if (!i_rstn || i_aclr) begin
			phase_r    <= 1'b0; // R9
			vec_hold_r <= {`CAM_WORDS{1'b0}};
			val_r      <= 1'b0;
			found_r    <= 1'b0;
			addr_r     <= {`CAM_AW{1'b0}};
			vec_r      <= {`CAM_HALF{1'b0}};
			upper_r    <= 1'b0;
		end else if (i_out_ce) begin // R9
			val_r <= 1'b0;
			if (phase_r) begin
				vec_r   <= vec_hold_r[`CAM_WORDS-1:`CAM_HALF]; // R4
				upper_r <= 1'b1;
				val_r   <= 1'b1;
				phase_r <= 1'b0;
			end else if (take) begin
				vec_hold_r <= hit; // R5
				found_r    <= |hit; // R10
				addr_r     <= cam_enc(hit); // R3
				vec_r      <= ctrl_unenc_r ? hit[`CAM_HALF-1:0] : {`CAM_HALF{1'b0}}; // R4
				upper_r    <= 1'b0;
				val_r      <= 1'b1;
				phase_r    <= ctrl_unenc_r; // R4
			end
		end else begin
			val_r <= 1'b0;
		end
	end

	// Optional output register stage
	// It trades one cycle of latency for timing margin on the outputs
	reg                    val_q;
	reg                    found_q;
	reg  [`CAM_AW-1:0]     addr_q;
	reg  [`CAM_HALF-1:0]   vec_q;
	reg                    upper_q;

	always @(posedge i_clk or negedge i_rstn or posedge i_aclr) begin
		if (!i_rstn || i_aclr) begin
			val_q   <= 1'b0;
			found_q <= 1'b0;
			addr_q  <= {`CAM_AW{1'b0}};
			vec_q   <= {`CAM_HALF{1'b0}};
			upper_q <= 1'b0;
		end else if (i_out_ce) begin
			val_q   <= val_r; // R8
			found_q <= found_r;
			addr_q  <= addr_r;
			vec_q   <= vec_r;
			upper_q <= upper_r;
		end else begin
			val_q <= 1'b0;
		end
	end

	assign o_res_valid = (P_OUT_REG != 0) ? val_q   : val_r;
	assign o_res_found = (P_OUT_REG != 0) ? found_q : found_r;
	assign o_res_addr  = (P_OUT_REG != 0) ? addr_q  : addr_r;
	assign o_res_vec   = (P_OUT_REG != 0) ? vec_q   : vec_r;
	assign o_res_upper = (P_OUT_REG != 0) ? upper_q : upper_r;
	// Write completion pulse follows the committing edge
	assign o_wr_done   = wr_done_r;

	// ==================================================
	// Avalon-MM slave, one wait state per access
	reg                    ack_r;
	reg  [31:0]            rdata_r;
	reg  [31:0]            status_w;
	wire                   req;
	wire [2:0]             sel_w;
	wire                   ctrl_we;

	// The first cycle of every request waits and the second completes, so
	// read data is always loaded one edge before the master takes it
	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_r;
	assign o_avs_readdata    = rdata_r;

	// Register select shared by the read and write paths; unmapped offsets
	// select nothing, so they read as zero and drop writes
	function [2:0] cam_sel;
		input [3:0] a;
		begin
			if (a == `CAM_OFS_CTRL) begin
				cam_sel = 3'b001;
			end else if (a == `CAM_OFS_STATUS) begin
				cam_sel = 3'b010;
			end else if (a == `CAM_OFS_VECTOR) begin
				cam_sel = 3'b100;
			end else begin
				cam_sel = 3'b000;
			end
		end
	endfunction

	assign sel_w = cam_sel(i_avs_address);

	// Status word, each field placed at its own bit position
	always @* begin
		status_w                              = 32'h0000_0000;
		status_w[`CAM_ST_FOUND]               = found_r; // R10
		status_w[`CAM_ST_ADDR_LSB +: `CAM_AW] = addr_r; // R3
		status_w[`CAM_ST_BUSY]                = (wcnt_r != 2'd0); // R7
	end

	// Handshake and read data capture
	// Read data is captured in the waiting cycle and then held
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			if (i_avs_read && !ack_r) begin
				if (sel_w[0]) begin
					rdata_r <= {31'h0000_0000, ctrl_unenc_r};
				end else if (sel_w[1]) begin
					rdata_r <= status_w;
				end else if (sel_w[2]) begin
					rdata_r <= vec_hold_r; // R5
				end else begin
					rdata_r <= 32'h0000_0000; // Unmapped reads zero
				end
			end
		end
	end

	// Control write lands only on the completing edge, never while waiting,
	// and only when the low byte lane is enabled
	assign ctrl_we = i_avs_write & ack_r & i_avs_byteenable[0] & sel_w[0];

	// Mode register
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_unenc_r <= `CAM_CTRL_RST;
		end else if (ctrl_we) begin
			ctrl_unenc_r <= i_avs_writedata[`CAM_CTRL_UNENC]; // R3 R4
		end
	end

endmodule

// file: dv/cam_sva.sv
`timescale 1ns/10ps
module cam_sva (
	input wire        i_clk,
	input wire        i_rstn,
	input wire        i_aclr,
	input wire        i_in_ce,
	input wire        i_out_ce,
	input wire        i_read_strobe,
	input wire        i_wr_en,
	input wire [31:0] i_wr_care,
	input wire        o_wr_done,
	input wire        o_res_valid,
	input wire        o_res_found,
	input wire [15:0] o_res_vec,
	input wire        o_res_upper
);
	// ====
	// Write and result timing
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn || i_aclr);
	wire wa = i_wr_en && i_in_ce;
	sequence s_p2; $rose(i_wr_en) && i_wr_care == 32'h0 ##0 wa [*2]; endsequence
	sequence s_m2; $rose(i_wr_en) && i_wr_care != 32'h0 ##0 wa [*2]; endsequence
	a_wr_plain: assert property (s_p2 |=> o_wr_done) else $error("no done");
	a_wr_mhold: assert property (s_m2 |=> !o_wr_done) else $error("early done");
	a_wr_mask: assert property (s_m2 ##1 wa |=> o_wr_done) else $error("no done");
	a_done_pulse: assert property (o_wr_done |=> !o_wr_done) else $error("long done");
	a_res_lat: assert property (i_read_strobe && i_in_ce ##1 i_out_ce |=> o_res_valid)
		else $error("no result");
	a_upper_after: assert property (o_res_valid && o_res_upper |->
		$past(o_res_valid) && !$past(o_res_upper)) else $error("lone upper");
	a_found_hold: assert property (!o_res_valid |-> $stable(o_res_found))
		else $error("found moved");
	a_aclr_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_aclr |-> !o_res_valid && o_res_vec == 16'h0) else $error("not cleared");
endmodule
bind cam_core cam_sva i_cam_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_aclr(i_aclr),
	.i_in_ce(i_in_ce), .i_out_ce(i_out_ce), .i_read_strobe(i_read_strobe),
	.i_wr_en(i_wr_en), .i_wr_care(i_wr_care), .o_wr_done(o_wr_done),
	.o_res_valid(o_res_valid), .o_res_found(o_res_found), .o_res_vec(o_res_vec),
	.o_res_upper(o_res_upper));

// file: dv/cam_fab_model.sv
`timescale 1ns/10ps
module cam_fab_model (
	input  wire         i_clk,
	output logic        o_wr_en,
	output logic [4:0]  o_wr_addr,
	output logic [31:0] o_wr_data,
	output logic [31:0] o_wr_care,
	output logic        o_strobe,
	output logic [31:0] o_key
);
	// ====
	// Fabric side driver, released data, care and key buses show the inverse; the write address keeps its value
	initial {o_wr_en, o_wr_addr, o_wr_data, o_wr_care, o_strobe, o_key} = '0;
	// Word write held for n clock cycles
	task wr(input logic [4:0] a, input logic [31:0] d, c, input int n);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_wr_addr <= a;
		o_wr_data <= d;
		o_wr_care <= c;
		repeat (n) @(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wr_data <= ~d;
		o_wr_care <= ~c;
	endtask
	// One search strobe
	task sr(input logic [31:0] k);
		@(posedge i_clk);
		o_strobe <= 1'b1;
		o_key <= k;
		@(posedge i_clk);
		o_strobe <= 1'b0;
		o_key <= ~k;
	endtask
endmodule

// file: dv/tb_content_addressable_memory.sv
`timescale 1ns/10ps
module tb_content_addressable_memory;
	// ====
	// Stimulus, model and result queue
	localparam logic [1023:0] PD = 1024'h1234_5678 << 160;
	logic i_clk = 0, i_rstn = 0, i_aclr = 0, i_in_ce = 1, i_out_ce = 1;
	logic i_avs_read = 0, i_avs_write = 0;
	logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
	logic [31:0] i_avs_writedata = 32'h0, m_d[32], m_c[32], m_v, r, d, c, lv;
	logic [4:0] la;
	logic [22:0] q[$];
	int err_total = 0, n_checks = 0;
	wire we, st, o_res_valid, o_res_found, o_res_upper, o_avs_waitrequest;
	wire [4:0] wa, o_res_addr;
	wire [15:0] o_res_vec;
	wire [31:0] wd, wc, key, o_avs_readdata;
	cam_fab_model i_cam_fab_model (.i_clk(i_clk), .o_wr_en(we), .o_wr_addr(wa),
		.o_wr_data(wd), .o_wr_care(wc), .o_strobe(st), .o_key(key));
	cam_core #(.P_INIT_DATA(PD), .P_INIT_VALID(32'h0000_0020)) i_cam_core (.i_clk(i_clk),
		.i_rstn(i_rstn), .i_aclr(i_aclr), .i_in_ce(i_in_ce), .i_out_ce(i_out_ce),
		.i_read_strobe(st), .i_key(key), .i_wr_en(we), .i_wr_addr(wa), .i_wr_data(wd),
		.i_wr_care(wc), .o_wr_done(), .o_res_valid(o_res_valid), .o_res_found(o_res_found),
		.o_res_addr(o_res_addr), .o_res_vec(o_res_vec), .o_res_upper(o_res_upper),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
	always #50 i_clk = ~i_clk;
	// Compare and count
	task chk(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t seen %h exp %h", $time, g, e);
		end
	endtask
	// Avalon access, held until waitrequest is seen low
	task avs(input bit w, input logic [3:0] ad, input logic [31:0] wdat);
		int t;
		t = 0;
		@(posedge i_clk);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= ad;
		i_avs_writedata <= wdat;
		do begin
			@(posedge i_clk);
			t++;
		end while (o_avs_waitrequest !== 1'b0 && t < 50);
		if (o_avs_waitrequest !== 1'b0) err_total++;
		r = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask
	// Write through the fabric driver, model updated only on a full count
	task do_wr(input logic [4:0] a, input logic [31:0] dd, cc, input int n);
		i_cam_fab_model.wr(a, dd, cc, n);
		if (n == 2 + (cc != 0)) begin
			m_d[a] = dd;
			m_c[a] = cc;
			m_v[a] = 1'b1;
		end
	endtask
	// Search with the expected notes queued first
	task do_sr(input logic [31:0] k, input bit u);
		logic [31:0] v;
		logic [4:0] a;
		v = 32'h0;
		a = 5'h0;
		for (int i = 31; i >= 0; i--) begin
			if (m_v[i] && ((m_d[i] ^ k) & ~m_c[i]) == 32'h0) begin
				v[i] = 1'b1;
				a = 5'(i);
			end
		end
		q.push_back({|v, a, u ? v[15:0] : 16'h0, 1'b0});
		if (u) q.push_back({|v, a, v[31:16], 1'b1});
		lv = v;
		la = a;
		i_cam_fab_model.sr(k);
	endtask
	// Result watcher, every field of both beats compared
	always @(posedge i_clk) begin
		logic [22:0] g, e;
		if (i_rstn && o_res_valid === 1'b1) begin
			g = {o_res_found, o_res_addr, o_res_vec, o_res_upper};
			e = (q.size() > 0) ? q.pop_front() : ~g;
			chk(32'(g), 32'(e));
		end
	end
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clk);
		err_total++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		m_v = 32'h0000_0020;
		m_d[5] = 32'h1234_5678;
		m_c[5] = 32'h0;
		void'($urandom(32'hc962f4ab));
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		avs(0, 4'h0, 32'h0);
		chk(r, 32'h0);
		avs(0, 4'hc, 32'h0);
		chk(r, 32'h0);
		do_sr(32'h1234_5678, 0);
		for (int i = 0; i < 32; i++) begin
			d = $urandom;
			c = (i % 4 == 0) ? $urandom & 32'h0000_00ff : 32'h0;
			do_wr(5'(i), d, c, 2 + (c != 0));
			do_sr(d ^ (c & $urandom), 0);
		end
		do_sr($urandom, 0);
		do_wr(5'h7, $urandom, 32'h0, 1);
		do_wr(5'h8, $urandom, 32'h1, 2);
		do_sr(m_d[7], 0);
		do_sr(m_d[8], 0);
		avs(1, 4'h0, 32'h1);
		avs(0, 4'h0, 32'h0);
		chk(r, 32'h1);
		i_avs_byteenable <= 4'he;
		avs(1, 4'h0, 32'h0);
		i_avs_byteenable <= 4'hf;
		avs(0, 4'h0, 32'h0);
		chk(r, 32'h1);
		do_wr(5'h3, 32'hcafe_0003, 32'h0, 2);
		do_wr(5'h14, 32'hcafe_0003, 32'h0, 2);
		do_sr(32'hcafe_0003, 1);
		avs(0, 4'h4, 32'h0);
		chk(r, {15'h0000, 1'b0, 3'h0, la, 7'h00, |lv});
		avs(0, 4'h8, 32'h0);
		chk(r, lv);
		do_sr(m_d[31], 1);
		i_in_ce <= 1'b0;
		i_cam_fab_model.sr(m_d[31]);
		i_in_ce <= 1'b1;
		i_cam_fab_model.sr(m_d[31]);
		i_aclr <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_aclr <= 1'b0;
		do_sr(m_d[0], 1);
		repeat (3) @(posedge i_clk);
		i_out_ce <= 1'b0;
		i_cam_fab_model.sr(m_d[0]);
		@(posedge i_clk);
		i_out_ce <= 1'b1;
		repeat (6) @(posedge i_clk);
		chk(q.size(), 32'h0);
		report_and_stop;
	end
endmodule
